// ### verilog/hbc_consts.svh
// register map, field positions and reset values of the sleep and wake controller
//
// Operation
// - with low-battery detect enabled, a low backup supply sets the low-battery raw flag
// - with abort also enabled, a sleep request is refused while battery is low
// - battery level is ignored while sleeping
// - a 32-bit seconds counter steps once per second
// - a predivider counts reference ticks down to make the seconds pulse
// - trim value is the divide count one second in 64; nominal 0x7fff
// - two match registers compare with the counter; wake when asleep, else interrupt
// - counter runs only when enabled; a load write replaces the count anytime
// - counter keeps running asleep or awake while counter and reference clock are enabled with good backup supply
// - 64 retained 32-bit words, read and written through the data window
// - regulator-off output asserts while asleep, released on a wake event
// - pin wake enable lets the wake pin end sleep; match wake enable a match
// - after wake the raw status still shows the wake cause
// - pin, match and low-battery events are ORed into one interrupt
// - raw status shows all events; masked status only the enabled ones
// - writing one to clear register drops that event; mask selects interrupt sources
// - control bit 2 selects oscillator when set, crystal divided by 128 when clear
// - the reference enable bit survives a wake and stays readable
// - write-done clears when a slow write starts, sets when it completes
// - system reset clears registers only when counter and pin wake are both off
`ifndef HBC_CONSTS_SVH
`define HBC_CONSTS_SVH

`define HBC_AW            9
`define HBC_OFS_COUNT     9'h000
`define HBC_OFS_MATCH0    9'h004
`define HBC_OFS_MATCH1    9'h008
`define HBC_OFS_LOAD      9'h00c
`define HBC_OFS_CTL       9'h010
`define HBC_OFS_MASK      9'h014
`define HBC_OFS_RAW       9'h018
`define HBC_OFS_MASKED    9'h01c
`define HBC_OFS_CLEAR     9'h020
`define HBC_OFS_TRIM      9'h024
`define HBC_OFS_DATA_LO   9'h030
`define HBC_OFS_DATA_HI   9'h12c

// control register fields
`define HBC_CTL_RUN       0
`define HBC_CTL_REQ       1
`define HBC_CTL_SEL       2
`define HBC_CTL_MWAKE     3
`define HBC_CTL_PWAKE     4
`define HBC_CTL_LBEN      5
`define HBC_CTL_CLKEN     6
`define HBC_CTL_ABORT     7
`define HBC_CTL_DONE      31

// event bits in raw, mask, masked and clear registers
`define HBC_EV_W          4
`define HBC_EV_M0         0
`define HBC_EV_M1         1
`define HBC_EV_LOWBATT_FLAG     2
`define HBC_EV_PIN        3

`define HBC_MATCH_RST     32'hffffffff
`define HBC_LOAD_RST      32'hffffffff
`define HBC_COUNT_RST     32'h00000000
`define HBC_TRIM_W        16
`define HBC_TRIM_RST      16'h7fff
`define HBC_DIV_NOMINAL   16'h7fff
`define HBC_TRIM_SECOND   6'h00
`define HBC_XTAL_LAST     7'h7f
`define HBC_WORDS         64

`endif

// ### verilog/hbc_pkg.sv
// shared types of the sleep and wake controller
package hbc_pkg;
   typedef enum logic {hbc_awake, hbc_asleep} hbc_state_e;
   typedef logic [5:0] hbc_index_t;
endpackage

// ### verilog/hbc_ref_tick.sv
// reference tick source: oscillator edge or crystal divided by 128
`include "hbc_consts.svh"
module hbc_ref_tick (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic wipe,
   // control
   input  wire logic ref_clock_en,
   input  wire logic ref_select,
   // reference inputs, already synchronous
   input  wire logic ref_osc_in,
   input  wire logic xtal_in,
   // one-cycle pulse per 32.768 kHz period
   output logic      ref_tick
);
   logic       osc_q;
   logic       xtal_q;
   logic [6:0] xtal_div;
   logic       osc_rise;
   logic       xtal_rise;

   assign osc_rise  = ref_osc_in & ~osc_q;
   assign xtal_rise = xtal_in & ~xtal_q;

   always_ff @(posedge core_clk) begin
      if (wipe) begin
         osc_q  <= 1'b0;
         xtal_q <= 1'b0;
      end else begin
         osc_q  <= ref_osc_in;
         xtal_q <= xtal_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (wipe || !ref_clock_en) begin
         xtal_div <= 7'h00;
      end else if (xtal_rise) begin
         xtal_div <= xtal_div + 7'h01;
      end
   end

   // crystal path only ticks once every 128 crystal edges
   always_ff @(posedge core_clk) begin
      if (wipe || !ref_clock_en) begin
         ref_tick <= 1'b0;
      end else if (ref_select) begin
         ref_tick <= osc_rise;
      end else begin
         ref_tick <= xtal_rise && (xtal_div == `HBC_XTAL_LAST);
      end
   end
endmodule

// ### verilog/hbc_rtc_core.sv
// predivider with trim and the 32-bit seconds counter
`include "hbc_consts.svh"
module hbc_rtc_core (
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   wipe,
   // timing and control
   input  wire logic                   ref_tick,
   input  wire logic                   run,
   input  wire logic [`HBC_TRIM_W-1:0] trim,
   // counter load
   input  wire logic                   load_stb,
   input  wire logic [31:0]            load_val,
   // counter state
   output logic [31:0]                 count,
   output logic                        count_step
);
   logic [`HBC_TRIM_W-1:0] prediv;
   logic [5:0]             second_idx;
   logic                   second_end;

   assign second_end = run && ref_tick && (prediv == '0);

   // the trimmed count is used for one second in each 64
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         prediv     <= `HBC_DIV_NOMINAL;
         second_idx <= 6'h00;
      end else if (second_end) begin
         second_idx <= second_idx + 6'h01;
         if (second_idx + 6'h01 == `HBC_TRIM_SECOND) begin
            prediv <= trim;
         end else begin
            prediv <= `HBC_DIV_NOMINAL;
         end
      end else if (run && ref_tick) begin
         prediv <= prediv - 16'h0001;
      end
   end

   // a load beats a tick in the same cycle; the new value is what software wants
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         count      <= `HBC_COUNT_RST;
         count_step <= 1'b0;
      end else if (load_stb) begin
         count      <= load_val;
         count_step <= 1'b1;
      end else if (second_end) begin
         count      <= count + 32'h00000001;
         count_step <= 1'b1;
      end else begin
         count_step <= 1'b0;
      end
   end
endmodule

// ### verilog/hbc_hibernate_ctrl.sv
// top of the sleep and wake controller: registers, retained words, sleep sequencing
//
// The strobed register port was decided locally.
`include "hbc_consts.svh"
module hbc_hibernate_ctrl (
   // clock and resets
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              power_lost,
   // register port
   input  wire logic [`HBC_AW-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   // reference clock pins
   input  wire logic              ref_osc_in,
   input  wire logic              xtal_in,
   // supply and wake pins
   input  wire logic              backup_ok,
   input  wire logic              lowbatt_in,
   input  wire logic              wake_n,
   // regulator control, open drain, and interrupt
   output logic                   regulator_off_out,
   output logic                   regulator_off_oe,
   output logic                   event_irq
);
   logic                   counter_en;
   logic                   ref_select;
   logic                   match_wake_en;
   logic                   pin_wake_en;
   logic                   lowbatt_detect_en;
   logic                   ref_clock_en;
   logic                   lowbatt_abort_en;
   logic                   write_pending;
   logic [31:0]            match_zero;
   logic [31:0]            match_one;
   logic [31:0]            counter_load;
   logic [`HBC_TRIM_W-1:0] predivider_trim;
   logic [`HBC_EV_W-1:0]   event_mask;
   logic [`HBC_EV_W-1:0]   raw_event_status;
   logic [`HBC_EV_W-1:0]   ev_set;
   logic [31:0]            retained_words [`HBC_WORDS];
   logic                   wake_n_q;
   hbc_pkg::hbc_state_e    state;
   logic                   wipe;
   logic                   ref_tick;
   logic                   run;
   logic [31:0]            count;
   logic                   count_step;
   logic                   ev_m0;
   logic                   ev_m1;
   logic                   wake_hit;
   logic                   wr_ctl;
   logic                   wr_slow;
   logic                   load_stb;
   logic                   sleep_refused;
   logic [31:0]            next_rdata;

   function automatic logic is_data(input logic [`HBC_AW-1:0] a);
      is_data = (a >= `HBC_OFS_DATA_LO) && (a <= `HBC_OFS_DATA_HI) && (a[1:0] == 2'b00);
   endfunction

   function automatic hbc_pkg::hbc_index_t data_index(input logic [`HBC_AW-1:0] a);
      logic [`HBC_AW-1:0] rel;
      rel = a - `HBC_OFS_DATA_LO;
      data_index = rel[7:2];
   endfunction

   // registers survive a system reset while the counter or pin wake is armed
   assign wipe = power_lost || (!nrst && !(counter_en || pin_wake_en));

   assign wr_ctl   = reg_wr && (reg_addr == `HBC_OFS_CTL);
   assign load_stb = reg_wr && (reg_addr == `HBC_OFS_LOAD);
   assign wr_slow  = reg_wr && ((reg_addr == `HBC_OFS_MATCH0) ||
                                (reg_addr == `HBC_OFS_MATCH1) ||
                                (reg_addr == `HBC_OFS_LOAD)   ||
                                (reg_addr == `HBC_OFS_TRIM)   ||
                                is_data(reg_addr));
   assign run = counter_en && ref_clock_en && backup_ok;

   hbc_ref_tick u_ref_tick (
      .core_clk     (core_clk),
      .wipe         (wipe),
      .ref_clock_en (ref_clock_en),
      .ref_select   (ref_select),
      .ref_osc_in   (ref_osc_in),
      .xtal_in      (xtal_in),
      .ref_tick     (ref_tick)
   );

   hbc_rtc_core u_rtc_core (
      .core_clk   (core_clk),
      .wipe       (wipe),
      .ref_tick   (ref_tick),
      .run        (run),
      .trim       (predivider_trim),
      .load_stb   (load_stb),
      .load_val   (reg_wdata),
      .count      (count),
      .count_step (count_step)
   );

   // a match only counts when the counter has just moved onto the value
   assign ev_m0 = count_step && (count == match_zero);
   assign ev_m1 = count_step && (count == match_one);

   assign wake_hit = (pin_wake_en && !wake_n) ||
                     (match_wake_en && (ev_m0 || ev_m1));

   // abort uses the enables in the same write, since software sets them together
   assign sleep_refused = reg_wdata[`HBC_CTL_LBEN] && reg_wdata[`HBC_CTL_ABORT] &&
                          lowbatt_in;

   // control register
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         counter_en        <= 1'b0;
         ref_select        <= 1'b0;
         match_wake_en     <= 1'b0;
         pin_wake_en       <= 1'b0;
         lowbatt_detect_en <= 1'b0;
         ref_clock_en      <= 1'b0;
         lowbatt_abort_en  <= 1'b0;
      end else if (wr_ctl) begin
         counter_en        <= reg_wdata[`HBC_CTL_RUN];
         ref_select        <= reg_wdata[`HBC_CTL_SEL];
         match_wake_en     <= reg_wdata[`HBC_CTL_MWAKE];
         pin_wake_en       <= reg_wdata[`HBC_CTL_PWAKE];
         lowbatt_detect_en <= reg_wdata[`HBC_CTL_LBEN];
         ref_clock_en      <= reg_wdata[`HBC_CTL_CLKEN];
         lowbatt_abort_en  <= reg_wdata[`HBC_CTL_ABORT];
      end
   end

   // slow-domain registers take the value at once; the done flag paces software
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         match_zero      <= `HBC_MATCH_RST;
         match_one       <= `HBC_MATCH_RST;
         counter_load    <= `HBC_LOAD_RST;
         predivider_trim <= `HBC_TRIM_RST;
         event_mask      <= '0;
      end else if (reg_wr) begin
         if (reg_addr == `HBC_OFS_MATCH0) begin
            match_zero <= reg_wdata;
         end
         if (reg_addr == `HBC_OFS_MATCH1) begin
            match_one <= reg_wdata;
         end
         if (reg_addr == `HBC_OFS_LOAD) begin
            counter_load <= reg_wdata;
         end
         if (reg_addr == `HBC_OFS_TRIM) begin
            predivider_trim <= reg_wdata[`HBC_TRIM_W-1:0];
         end
         if (reg_addr == `HBC_OFS_MASK) begin
            event_mask <= reg_wdata[`HBC_EV_W-1:0];
         end
      end
   end

   // write-done is low from a slow write until the next reference tick
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         write_pending <= 1'b0;
      end else if (wr_slow) begin
         write_pending <= 1'b1;
      end else if (ref_tick) begin
         write_pending <= 1'b0;
      end
   end

   // retained words have no reset: their content must outlive every reset
   always_ff @(posedge core_clk) begin
      if (reg_wr && is_data(reg_addr)) begin
         retained_words[data_index(reg_addr)] <= reg_wdata;
      end
   end

   // sleep sequencing
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         state <= hbc_pkg::hbc_awake;
      end else begin
         unique case (state)
            hbc_pkg::hbc_awake: begin
               if (wr_ctl && reg_wdata[`HBC_CTL_REQ] && !sleep_refused) begin
                  state <= hbc_pkg::hbc_asleep;
               end
            end
            hbc_pkg::hbc_asleep: begin
               if (wake_hit) begin
                  state <= hbc_pkg::hbc_awake;
               end
            end
         endcase
      end
   end

   // open-drain regulator control: pulled low while asleep, released otherwise
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         regulator_off_out <= 1'b0;
         regulator_off_oe  <= 1'b0;
      end else begin
         regulator_off_out <= 1'b0;
         regulator_off_oe  <= (state == hbc_pkg::hbc_awake) ?
                              (wr_ctl && reg_wdata[`HBC_CTL_REQ] && !sleep_refused) :
                              !wake_hit;
      end
   end

   // event sources
   always_comb begin
      ev_set                = '0;
      ev_set[`HBC_EV_M0]    = ev_m0;
      ev_set[`HBC_EV_M1]    = ev_m1;
      ev_set[`HBC_EV_LOWBATT_FLAG] = lowbatt_detect_en && lowbatt_in &&
                               (state == hbc_pkg::hbc_awake);
      ev_set[`HBC_EV_PIN]   = pin_wake_en && wake_n_q && !wake_n;
   end

   always_ff @(posedge core_clk) begin
      if (wipe) begin
         wake_n_q <= 1'b1;
      end else begin
         wake_n_q <= wake_n;
      end
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         raw_event_status <= '0;
      end else if (reg_wr && (reg_addr == `HBC_OFS_CLEAR)) begin
         raw_event_status <= (raw_event_status & ~reg_wdata[`HBC_EV_W-1:0]) |
                             ev_set;
      end else begin
         raw_event_status <= raw_event_status | ev_set;
      end
   end

   // single request line; held off while asleep since the processor is unpowered
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         event_irq <= 1'b0;
      end else begin
         event_irq <= (|(raw_event_status & event_mask)) &&
                      (state == hbc_pkg::hbc_awake);
      end
   end

   // read path
   always_comb begin
      next_rdata = '0;
      if (is_data(reg_addr)) begin
         next_rdata = retained_words[data_index(reg_addr)];
      end else begin
         unique case (reg_addr)
            `HBC_OFS_COUNT:  next_rdata = count;
            `HBC_OFS_MATCH0: next_rdata = match_zero;
            `HBC_OFS_MATCH1: next_rdata = match_one;
            `HBC_OFS_LOAD:   next_rdata = counter_load;
            `HBC_OFS_CTL: begin
               next_rdata[`HBC_CTL_RUN]   = counter_en;
               next_rdata[`HBC_CTL_REQ]   = (state == hbc_pkg::hbc_asleep);
               next_rdata[`HBC_CTL_SEL]   = ref_select;
               next_rdata[`HBC_CTL_MWAKE] = match_wake_en;
               next_rdata[`HBC_CTL_PWAKE] = pin_wake_en;
               next_rdata[`HBC_CTL_LBEN]  = lowbatt_detect_en;
               next_rdata[`HBC_CTL_CLKEN] = ref_clock_en;
               next_rdata[`HBC_CTL_ABORT] = lowbatt_abort_en;
               next_rdata[`HBC_CTL_DONE]  = !write_pending;
            end
            `HBC_OFS_MASK:   next_rdata[`HBC_EV_W-1:0] = event_mask;
            `HBC_OFS_RAW:    next_rdata[`HBC_EV_W-1:0] = raw_event_status;
            `HBC_OFS_MASKED: next_rdata[`HBC_EV_W-1:0] =
                                raw_event_status & event_mask;
            `HBC_OFS_TRIM:   next_rdata[`HBC_TRIM_W-1:0] = predivider_trim;
            default:         next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (wipe) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= '0;
      end
   end
endmodule

// ### dv/hbc_checker.sv
// port-level assertions for the sleep and wake controller
`include "hbc_consts.svh"
module hbc_checker (
   // clock and resets
   input wire logic               core_clk,
   input wire logic               nrst,
   input wire logic               power_lost,
   // register port
   input wire logic [`HBC_AW-1:0] reg_addr,
   input wire logic [31:0]        reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [31:0]        reg_rdata,
   // pins
   input wire logic               ref_osc_in,
   input wire logic               xtal_in,
   input wire logic               backup_ok,
   input wire logic               lowbatt_in,
   input wire logic               wake_n,
   input wire logic               regulator_off_out,
   input wire logic               regulator_off_oe,
   input wire logic               event_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  ctl_q;
   logic [3:0]  mask_q;
   logic [31:0] m0_q;
   logic        wipe;
   logic        ctl_wr;
   // shadows of software writes, wiped like the block
   assign wipe = power_lost | (!nrst & !(ctl_q[`HBC_CTL_RUN] | ctl_q[`HBC_CTL_PWAKE]));
   assign ctl_wr = reg_wr && reg_addr == `HBC_OFS_CTL;
   always_ff @(posedge core_clk) begin
      if (wipe) begin
         ctl_q  <= 8'h00;
         mask_q <= 4'h0;
         m0_q   <= 32'hffffffff;
      end else if (reg_wr) begin
         if (reg_addr == `HBC_OFS_CTL) ctl_q <= reg_wdata[7:0];
         if (reg_addr == `HBC_OFS_MASK) mask_q <= reg_wdata[3:0];
         if (reg_addr == `HBC_OFS_MATCH0) m0_q <= reg_wdata;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (power_lost || !nrst);
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero");
   a_odrain_level: assert property (regulator_off_out == 1'b0)
      else $error("pin drive not low");
   a_sleep_entry: assert property (ctl_wr && reg_wdata[1] && wake_n && !regulator_off_oe
      && !(reg_wdata[5] && reg_wdata[7] && lowbatt_in) |=> ##1 regulator_off_oe)
      else $error("sleep not entered");
   a_abort_refuse: assert property (ctl_wr && reg_wdata[1] && reg_wdata[5] && reg_wdata[7]
      && lowbatt_in && !regulator_off_oe && !$past(reg_wr) |=> ##1 !regulator_off_oe)
      else $error("sleep despite abort");
   a_irq_sleep_quiet: assert property (regulator_off_oe && $past(regulator_off_oe)
      |-> !event_irq)
      else $error("irq while asleep");
   a_pin_wake: assert property (regulator_off_oe && ctl_q[`HBC_CTL_PWAKE] && !wake_n
      |-> ##[1:4] !regulator_off_oe)
      else $error("wake pin did not end sleep");
   a_irq_masked: assert property (event_irq |-> (mask_q | $past(mask_q)) != 4'h0)
      else $error("irq while all masked");
   a_match_irq: assert property (reg_wr && reg_addr == `HBC_OFS_LOAD && reg_wdata == m0_q
      && mask_q[`HBC_EV_M0] && !regulator_off_oe |-> ##[1:4] event_irq)
      else $error("no match irq");
   a_lowbatt_irq: assert property ((lowbatt_in && ctl_q[`HBC_CTL_LBEN]
      && mask_q[`HBC_EV_LOWBATT_FLAG] && !regulator_off_oe)[*4] |-> event_irq)
      else $error("no low battery irq");
   c_sleep: cover property ($rose(regulator_off_oe));
   c_wake: cover property ($fell(regulator_off_oe));
   c_irq: cover property ($rose(event_irq));
endmodule

bind hbc_hibernate_ctrl hbc_checker i_hbc_checker (.*);

// ### dv/hbc_far_side.sv
// far side model: external regulator, wake source and reference oscillator
module hbc_far_side (
   // clock
   input  wire logic core_clk,
   // open-drain regulator enable
   input  wire logic regulator_off_out,
   input  wire logic regulator_off_oe,
   // bench command
   input  wire logic press_wake,
   // toward the controller and the bench
   output logic      wake_n,
   output logic      ref_osc_in,
   output logic      supply_on
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pin_level;
   // pull-up: regulator on unless sunk
   assign pin_level = regulator_off_oe ? regulator_off_out : 1'b1;
   assign supply_on = pin_level;
   // weak pull-up on the wake pin
   assign wake_n = !press_wake;
   // fast reference keeps one second short
   initial ref_osc_in = 1'b0;
   always @(posedge core_clk) ref_osc_in <= ~ref_osc_in;
endmodule

// ### dv/tb.sv
// self-checking bench for the sleep and wake controller
`include "hbc_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic        w;
      logic [8:0]  wa;
      logic [31:0] wd;
      logic [8:0]  ra;
      logic [31:0] ex;
   } hbc_row_s;
   logic        core_clk, nrst, power_lost, reg_wr, reg_rd, xtal_in, backup_ok;
   logic        lowbatt_in, press_wake, wake_n, ref_osc_in, supply_on;
   logic        regulator_off_out, regulator_off_oe, event_irq;
   logic [8:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   int          errors = 0, checks = 0, cyc = 0, t0, n;
   hbc_row_s    rows [0:17] = '{
      '{'0, '0, '0, `HBC_OFS_MATCH0, 32'hffffffff},
      '{'0, '0, '0, `HBC_OFS_MATCH1, 32'hffffffff},
      '{'0, '0, '0, `HBC_OFS_LOAD, 32'hffffffff},
      '{'0, '0, '0, `HBC_OFS_CTL, 32'h80000000},
      '{'0, '0, '0, `HBC_OFS_MASK, 32'h0},
      '{'0, '0, '0, `HBC_OFS_RAW, 32'h0},
      '{'0, '0, '0, `HBC_OFS_TRIM, 32'h7fff},
      '{'0, '0, '0, `HBC_OFS_COUNT, 32'h0},
      '{1'h1, `HBC_OFS_CTL, 32'h44, `HBC_OFS_CTL, 32'h80000044},
      '{1'h1, `HBC_OFS_MATCH0, 32'h12345678, `HBC_OFS_MATCH0, 32'h12345678},
      '{1'h1, `HBC_OFS_MATCH1, 32'ha5a55a5a, `HBC_OFS_MATCH1, 32'ha5a55a5a},
      '{1'h1, `HBC_OFS_LOAD, 32'h55, `HBC_OFS_COUNT, 32'h55},
      '{1'h1, `HBC_OFS_COUNT, 32'hdeadbeef, `HBC_OFS_COUNT, 32'h55},
      '{1'h1, `HBC_OFS_TRIM, 32'h1abcd, `HBC_OFS_TRIM, 32'habcd},
      '{1'h1, `HBC_OFS_MASK, 32'hff, `HBC_OFS_MASK, 32'hf},
      '{1'h1, `HBC_OFS_DATA_LO, 32'hcafef00d, `HBC_OFS_DATA_LO, 32'hcafef00d},
      '{1'h1, `HBC_OFS_DATA_HI, 32'h01234567, `HBC_OFS_DATA_HI, 32'h01234567},
      '{1'h1, 9'h028, 32'hffffffff, 9'h028, 32'h0}};

   hbc_hibernate_ctrl i_hbc_hibernate_ctrl (.core_clk(core_clk), .nrst(nrst),
      .power_lost(power_lost), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_osc_in(ref_osc_in), .xtal_in(xtal_in),
      .backup_ok(backup_ok), .lowbatt_in(lowbatt_in), .wake_n(wake_n),
      .regulator_off_out(regulator_off_out), .regulator_off_oe(regulator_off_oe),
      .event_irq(event_irq));
   hbc_far_side i_hbc_far_side (.core_clk(core_clk), .regulator_off_out(regulator_off_out),
      .regulator_off_oe(regulator_off_oe), .press_wake(press_wake), .wake_n(wake_n),
      .ref_osc_in(ref_osc_in), .supply_on(supply_on));

   task automatic close_out;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input logic [8:0] a, input logic [31:0] ex);
      logic [31:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), d, ex);
   endtask
   // poll write_done rather than wait blind
   task automatic wait_done;
      logic [31:0] d;
      int k;
      k = 0;
      do begin
         rd(`HBC_OFS_CTL, d);
         k++;
      end while (d[31] !== 1'b1 && k < 40);
      chk("write_done", {31'h0, d[31]}, 32'h1);
   endtask
   task automatic por;
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         errors++;
         close_out;
      end
   end

   initial begin
      nrst = 1'b0;
      power_lost = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 9'h0;
      reg_wdata = 32'h0;
      xtal_in = 1'b0;
      backup_ok = 1'b1;
      lowbatt_in = 1'b0;
      press_wake = 1'b0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      power_lost <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr(rows[i].wa, rows[i].wd);
            wait_done;
         end
         rdchk(rows[i].ra, rows[i].ex);
      end
      // crystal path with no crystal: write stays pending
      wr(`HBC_OFS_CTL, 32'h40);
      wr(`HBC_OFS_MATCH0, 32'h11);
      cycles(40);
      rd(`HBC_OFS_CTL, v);
      chk("no tick on crystal path", {31'h0, v[31]}, 32'h0);
      wr(`HBC_OFS_CTL, 32'h44);
      wait_done;
      wr(`HBC_OFS_MASK, 32'h1);
      wr(`HBC_OFS_MATCH0, 32'h100);
      wait_done;
      wr(`HBC_OFS_MATCH1, 32'h100);
      wait_done;
      wr(`HBC_OFS_LOAD, 32'h100);
      wait_done;
      rdchk(`HBC_OFS_RAW, 32'h3);
      rdchk(`HBC_OFS_MASKED, 32'h1);
      chk("irq on match", {31'h0, event_irq}, 32'h1);
      wr(`HBC_OFS_CLEAR, 32'h1);
      cycles(2);
      rdchk(`HBC_OFS_RAW, 32'h2);
      chk("irq after clear", {31'h0, event_irq}, 32'h0);
      lowbatt_in <= 1'b1;
      cycles(4);
      rdchk(`HBC_OFS_RAW, 32'h2);
      wr(`HBC_OFS_CTL, 32'h64);
      cycles(3);
      rdchk(`HBC_OFS_RAW, 32'h6);
      wr(`HBC_OFS_MASK, 32'h4);
      cycles(2);
      chk("irq on low battery", {31'h0, event_irq}, 32'h1);
      wr(`HBC_OFS_CTL, 32'hf6);
      cycles(3);
      chk("abort keeps power", {31'h0, regulator_off_oe}, 32'h0);
      rd(`HBC_OFS_CTL, v);
      chk("abort request bit", {31'h0, v[1]}, 32'h0);
      lowbatt_in <= 1'b0;
      wr(`HBC_OFS_CLEAR, 32'hf);
      wr(`HBC_OFS_CTL, 32'h76);
      cycles(2);
      chk("asleep oe", {31'h0, regulator_off_oe}, 32'h1);
      chk("supply off", {31'h0, supply_on}, 32'h0);
      lowbatt_in <= 1'b1;
      cycles(5);
      chk("irq asleep", {31'h0, event_irq}, 32'h0);
      lowbatt_in <= 1'b0;
      cycles(2);
      press_wake <= 1'b1;
      n = 0;
      while (supply_on !== 1'b1 && n < 8) begin
         cycles(1);
         n++;
      end
      chk("supply back", {31'h0, supply_on}, 32'h1);
      press_wake <= 1'b0;
      por;
      rdchk(`HBC_OFS_RAW, 32'h8);
      rd(`HBC_OFS_CTL, v);
      chk("ref enable kept", {31'h0, v[6]}, 32'h1);
      rdchk(`HBC_OFS_DATA_LO, 32'hcafef00d);
      rdchk(`HBC_OFS_MATCH0, 32'h100);
      wr(`HBC_OFS_CTL, 32'h44);
      por;
      rdchk(`HBC_OFS_MATCH0, 32'hffffffff);
      rdchk(`HBC_OFS_CTL, 32'h80000000);
      wr(`HBC_OFS_CTL, 32'h44);
      wr(`HBC_OFS_MATCH0, 32'h1);
      wait_done;
      wr(`HBC_OFS_LOAD, 32'h0);
      wait_done;
      wr(`HBC_OFS_CTL, 32'h4f);
      t0 = cyc;
      cycles(3);
      n = 0;
      while (regulator_off_oe === 1'b1 && n < 70000) begin
         cycles(1);
         n++;
      end
      // 32768 ticks, two core cycles each
      chk("one second", {31'h0, (cyc - t0) >= 65530 && (cyc - t0) <= 65560}, 32'h1);
      rdchk(`HBC_OFS_COUNT, 32'h1);
      rdchk(`HBC_OFS_RAW, 32'h1);
      close_out;
   end
endmodule
